// ==== design/btl_pkg.sv ====
// btl_pkg: register map, field layout, reset values and scaling for the limiter block
// assumes an 8-bit register port from the control interface and 8-bit supply readings
package btl_pkg;
  // register offsets
  localparam logic [7:0] LEFT_MODE_RATES_OFF   = 8'h0E;
  localparam logic [7:0] LEFT_THRESH_SLOPE_OFF = 8'h0F;
  localparam logic [7:0] LEFT_KNEE_OFF         = 8'h10;
  localparam logic [7:0] RIGHT_MODE_RATES_OFF  = 8'h11;
  localparam logic [7:0] RIGHT_THRESH_SLOPE_OFF = 8'h12;
  localparam logic [7:0] RIGHT_KNEE_OFF        = 8'h13;
  localparam logic [7:0] LEFT_CLIP_OFF         = 8'h14;
  localparam logic [7:0] RIGHT_CLIP_OFF        = 8'h15;
  localparam logic [7:0] STATUS2_OFF           = 8'h19;
  localparam logic [7:0] SUPPLY_OFF            = 8'h1A;
  // reset values
  localparam logic [7:0] LEFT_MODE_RATES_RST   = 8'hA0;
  localparam logic [7:0] RIGHT_MODE_RATES_RST  = 8'hA8;
  localparam logic [7:0] THRESH_SLOPE_RST      = 8'h51;
  localparam logic [7:0] KNEE_RST              = 8'h22;
  localparam logic [7:0] CLIP_RST              = 8'hFF;
  // field positions
  localparam int MODE_LSB    = 0;
  localparam int TRACK_BIT   = 2;
  localparam int ATTACK_LSB  = 4;
  localparam int RELEASE_LSB = 6;
  localparam int SLOPE_LSB   = 0;
  localparam int THRESH_LSB  = 3;
  localparam int LEFT_FLAG_BIT  = 3;
  localparam int RIGHT_FLAG_BIT = 7;
  // modes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_ALWAYS = 2'h1;
  localparam logic [1:0] MODE_MUTE   = 2'h2;
  localparam logic [1:0] MODE_LOWBAT = 2'h3;
  // supply scale: 3.8 V + 12.4 V * code / 255, in millivolts
  localparam int SUPPLY_BASE_MV = 3800;
  localparam int SUPPLY_SPAN_MV = 12400;
  localparam int SUPPLY_CODES   = 255;
  // threshold scale: 5-bit code spans 2 V to 16 V peak
  localparam int THRESH_MIN_MV  = 2000;
  localparam int THRESH_MAX_MV  = 16000;
  localparam int THRESH_CODES   = 31;
  // hysteresis on knee release, in supply codes
  localparam logic [7:0] KNEE_HYST = 8'h04;
  // gain: unity is 0x100 in an unsigned 9-bit word
  localparam logic [8:0] GAIN_UNITY = 9'h100;
  // attack and release step size per sample at rate code 0; attack halves and release doubles per rate code step
  localparam logic [8:0] ATTACK_STEP_0  = 9'h040;
  localparam logic [8:0] RELEASE_STEP_0 = 9'h001;
endpackage

// ==== design/btl_limiter.sv ====
// btl_limiter: two-channel battery tracking limiter and high-frequency clipper
// assumes samples come from the interpolator already upsampled, one valid/ready stream per pair,
// register writes arrive on a byte port from the control interface, supply code from the adc
//
// Functional notes
// - tracking adjusts threshold from supply automatically
// - per-channel 8-bit battery knee register
// - knee and supply share linear code scale
// - above knee inactive, below knee active
// - 2-bit slope field sets 1:1 to 4:1
// - reduction equals slope times supply drop
// - mode 00 disables limiting entirely
// - mode 01 always limits, tracking lowers threshold
// - mode 10 mutes below knee
// - mode 11 limits only below knee
// - knee release uses hysteresis
// - attack rate from bits 5:4
// - release rate from bits 7:6
// - per-channel 8-bit clip level registers
// - clipper saturates after interpolation
// - 5-bit threshold spans 2 V to 16 V
// - below threshold passes, above holds threshold
// - 8-bit supply reading feeds knee compare
// - status flag shows limiting engaged
`timescale 1ns/1ps
module btl_limiter #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  // register port
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  // supply reading from the sensing adc
  input  wire logic [7:0]          supply_code,
  // input stream, one stereo pair per beat
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [SAMPLE_W-1:0] in_left,
  input  wire logic [SAMPLE_W-1:0] in_right,
  // output stream
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [SAMPLE_W-1:0]      out_left,
  output logic [SAMPLE_W-1:0]      out_right
);

  if (SAMPLE_W < 10 || SAMPLE_W > 32) begin : g_chk
    $error("btl_limiter: SAMPLE_W must lie in 10..32");
  end

  localparam int MAG_W = SAMPLE_W - 1;

  typedef struct packed {
    logic [7:0]          mode_rates;
    logic [7:0]          thresh_slope;
    logic [7:0]          knee;
    logic [7:0]          clip;
    // latched copies used by the datapath
    logic [7:0]          act_mode_rates;
    logic [7:0]          act_thresh_slope;
    logic [7:0]          act_knee;
    logic [7:0]          act_clip;
    logic                low_bat;
    logic [8:0]          gain;
    logic                engaged;
  } btl_chan_type;

  typedef struct packed {
    btl_chan_type [1:0]  ch;
    logic [7:0]          sup_meta;
    logic [7:0]          sup;
    logic [1:0]          buf_cnt;
    logic [1:0][2*SAMPLE_W-1:0] buf_data;
    logic [7:0]          rdata;
    // handshake flags kept in flops so the ports carry no decode logic
    logic                in_rdy;
    logic                out_vld;
  } btl_state_type;

  btl_state_type st_r;
  btl_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // helper functions

  // effective threshold as a magnitude scaled to full scale
  function automatic logic [MAG_W-1:0] thresh_mag(input logic [4:0] code,
                                                 input logic [7:0] drop_code,
                                                 input logic [1:0] slope,
                                                 input logic       track);
    logic [31:0] thr_mv;
    logic [31:0] red_mv;
    logic [63:0] mag;
    thr_mv = 32'(btl_pkg::THRESH_MIN_MV)
           + 32'(code)
           * 32'((btl_pkg::THRESH_MAX_MV - btl_pkg::THRESH_MIN_MV) / btl_pkg::THRESH_CODES);
    red_mv = 32'(0);
    if (track) begin
      red_mv = (32'(slope) + 32'd1) * 32'(drop_code) * 32'(btl_pkg::SUPPLY_SPAN_MV)
               / 32'(btl_pkg::SUPPLY_CODES);
    end
    if (red_mv + 32'(btl_pkg::THRESH_MIN_MV) >= thr_mv) thr_mv = 32'(btl_pkg::THRESH_MIN_MV);
    else thr_mv = thr_mv - red_mv;
    // map 16 V peak to full scale
    mag = 64'(thr_mv) * 64'((64'd1 << MAG_W) - 64'd1) / 64'(btl_pkg::THRESH_MAX_MV);
    return mag[MAG_W-1:0];
  endfunction

  // saturate a signed sample to a magnitude limit
  function automatic logic [SAMPLE_W-1:0] sat(input logic [SAMPLE_W-1:0] s,
                                              input logic [MAG_W-1:0]    lim);
    logic [SAMPLE_W-1:0] pos;
    pos = {1'b0, lim};
    if (!s[SAMPLE_W-1] && s > pos) return pos;
    if (s[SAMPLE_W-1] && (~s + 1'b1) > pos) return ~pos + 1'b1;
    return s;
  endfunction

  // apply gain word (unity 0x100)
  function automatic logic [SAMPLE_W-1:0] scale(input logic [SAMPLE_W-1:0] s,
                                                input logic [8:0]          g);
    logic signed [SAMPLE_W+9:0] p;
    p = $signed({{10{s[SAMPLE_W-1]}}, s}) * $signed({{(SAMPLE_W+1){1'b0}}, g});
    return p[SAMPLE_W+7:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic                       take;
  logic                       give;
  logic [1:0][SAMPLE_W-1:0]   smp;
  logic [1:0][SAMPLE_W-1:0]   res;
  logic [1:0][MAG_W-1:0]      lim;
  logic [1:0][7:0]            drop;
  logic [1:0]                 limit_on;
  logic [1:0]                 muted;
  logic [1:0]                 over;
  logic [1:0][8:0]            g_use;
  logic [8:0]                 a_step;
  logic [8:0]                 r_step;

  always_comb begin
    st_nxt = st_r;
    take   = in_valid && (st_r.buf_cnt != 2'h2);
    give   = (st_r.buf_cnt != 2'h0) && out_ready;
    smp[0] = in_left;
    smp[1] = in_right;
    // two-stage capture of the adc reading
    st_nxt.sup_meta = supply_code;
    st_nxt.sup      = st_r.sup_meta;
    for (int c = 0; c < 2; c++) begin
      // knee and reading on the same code scale
      drop[c] = (st_r.sup < st_r.ch[c].act_knee) ? (st_r.ch[c].act_knee - st_r.sup) : 8'h00;
      // engage below knee, release above knee plus hysteresis
      if (st_r.sup < st_r.ch[c].act_knee) st_nxt.ch[c].low_bat = 1'b1;
      else if ({1'b0, st_r.sup} > {1'b0, st_r.ch[c].act_knee} + {1'b0, btl_pkg::KNEE_HYST})
        st_nxt.ch[c].low_bat = 1'b0;
      // threshold follows supply with tracking set
      lim[c] = thresh_mag(st_r.ch[c].act_thresh_slope[7:btl_pkg::THRESH_LSB],
                          st_r.ch[c].low_bat ? drop[c] : 8'h00,
                          st_r.ch[c].act_thresh_slope[btl_pkg::SLOPE_LSB+:2],
                          st_r.ch[c].act_mode_rates[btl_pkg::TRACK_BIT]);
      limit_on[c] = 1'b0;
      muted[c]    = 1'b0;
      unique case (st_r.ch[c].act_mode_rates[btl_pkg::MODE_LSB+:2])
        btl_pkg::MODE_OFF:    limit_on[c] = 1'b0;
        btl_pkg::MODE_ALWAYS: limit_on[c] = 1'b1;
        btl_pkg::MODE_MUTE: begin
          limit_on[c] = 1'b1;
          muted[c]    = st_r.ch[c].low_bat;
        end
        btl_pkg::MODE_LOWBAT: limit_on[c] = st_r.ch[c].low_bat;
      endcase
      g_use[c] = limit_on[c] ? st_r.ch[c].gain : btl_pkg::GAIN_UNITY;
      res[c]   = scale(smp[c], g_use[c]);
      over[c]  = limit_on[c] && (sat(smp[c], lim[c]) != smp[c]);
      if (limit_on[c]) res[c] = sat(res[c], lim[c]);
      if (muted[c]) res[c] = '0;
      res[c] = sat(res[c], {st_r.ch[c].act_clip, {(MAG_W-8){1'b1}}});
      a_step = btl_pkg::ATTACK_STEP_0 >> st_r.ch[c].act_mode_rates[btl_pkg::ATTACK_LSB+:2];
      r_step = btl_pkg::RELEASE_STEP_0 << st_r.ch[c].act_mode_rates[btl_pkg::RELEASE_LSB+:2];
      if (take) begin
        if (over[c]) begin
          st_nxt.ch[c].gain = (st_r.ch[c].gain > a_step) ? st_r.ch[c].gain - a_step : 9'h000;
        end else if (st_r.ch[c].gain < btl_pkg::GAIN_UNITY) begin
          st_nxt.ch[c].gain = (btl_pkg::GAIN_UNITY - st_r.ch[c].gain > r_step) ?
                              st_r.ch[c].gain + r_step : btl_pkg::GAIN_UNITY;
        end
        if (!limit_on[c]) st_nxt.ch[c].gain = btl_pkg::GAIN_UNITY;
        st_nxt.ch[c].engaged = muted[c] || over[c] || (limit_on[c] &&
                               st_nxt.ch[c].gain < btl_pkg::GAIN_UNITY);
        st_nxt.ch[c].act_mode_rates   = st_r.ch[c].mode_rates;
        st_nxt.ch[c].act_thresh_slope = st_r.ch[c].thresh_slope;
        st_nxt.ch[c].act_knee         = st_r.ch[c].knee;
        st_nxt.ch[c].act_clip         = st_r.ch[c].clip;
      end
    end
    // two-entry buffer: entry 0 is head
    if (give) begin
      st_nxt.buf_data[0] = st_r.buf_data[1];
    end
    if (take) begin
      if (st_r.buf_cnt == 2'h0 || (st_r.buf_cnt == 2'h1 && give))
        st_nxt.buf_data[0] = {res[1], res[0]};
      else st_nxt.buf_data[1] = {res[1], res[0]};
    end
    st_nxt.buf_cnt = st_r.buf_cnt + {1'b0, take} - {1'b0, give};
    // flags follow the next count so they stand with the data they describe
    st_nxt.in_rdy  = (st_nxt.buf_cnt != 2'h2);
    st_nxt.out_vld = (st_nxt.buf_cnt != 2'h0);
    if (reg_wr) begin
      unique case (reg_addr)
        // reserved bits are dropped so they read back as zero, except in the right mode/rates register, which stores all 8 bits
        btl_pkg::LEFT_MODE_RATES_OFF: begin
          st_nxt.ch[0].mode_rates = {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
        end
        btl_pkg::LEFT_THRESH_SLOPE_OFF: begin
          st_nxt.ch[0].thresh_slope = {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
        end
        btl_pkg::LEFT_KNEE_OFF:          st_nxt.ch[0].knee         = reg_wdata;
        btl_pkg::RIGHT_MODE_RATES_OFF:   st_nxt.ch[1].mode_rates   = reg_wdata;
        btl_pkg::RIGHT_THRESH_SLOPE_OFF: begin
          st_nxt.ch[1].thresh_slope = {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
        end
        btl_pkg::RIGHT_KNEE_OFF:         st_nxt.ch[1].knee         = reg_wdata;
        btl_pkg::LEFT_CLIP_OFF:          st_nxt.ch[0].clip         = reg_wdata;
        btl_pkg::RIGHT_CLIP_OFF:         st_nxt.ch[1].clip         = reg_wdata;
        default: ;
      endcase
    end
    // registered readback of the addressed register
    unique case (reg_addr)
      btl_pkg::LEFT_MODE_RATES_OFF:    st_nxt.rdata = st_r.ch[0].mode_rates;
      btl_pkg::LEFT_THRESH_SLOPE_OFF:  st_nxt.rdata = st_r.ch[0].thresh_slope;
      btl_pkg::LEFT_KNEE_OFF:          st_nxt.rdata = st_r.ch[0].knee;
      btl_pkg::RIGHT_MODE_RATES_OFF:   st_nxt.rdata = st_r.ch[1].mode_rates;
      btl_pkg::RIGHT_THRESH_SLOPE_OFF: st_nxt.rdata = st_r.ch[1].thresh_slope;
      btl_pkg::RIGHT_KNEE_OFF:         st_nxt.rdata = st_r.ch[1].knee;
      btl_pkg::LEFT_CLIP_OFF:          st_nxt.rdata = st_r.ch[0].clip;
      btl_pkg::RIGHT_CLIP_OFF:         st_nxt.rdata = st_r.ch[1].clip;
      btl_pkg::STATUS2_OFF: begin
        st_nxt.rdata = 8'h00;
        st_nxt.rdata[btl_pkg::LEFT_FLAG_BIT]  = st_r.ch[0].engaged;
        st_nxt.rdata[btl_pkg::RIGHT_FLAG_BIT] = st_r.ch[1].engaged;
      end
      btl_pkg::SUPPLY_OFF:             st_nxt.rdata = st_r.sup;
      default:                         st_nxt.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.in_rdy                 <= 1'b1;
      st_r.ch[0].mode_rates       <= btl_pkg::LEFT_MODE_RATES_RST;
      st_r.ch[1].mode_rates       <= btl_pkg::RIGHT_MODE_RATES_RST;
      st_r.ch[0].act_mode_rates   <= btl_pkg::LEFT_MODE_RATES_RST;
      st_r.ch[1].act_mode_rates   <= btl_pkg::RIGHT_MODE_RATES_RST;
      for (int c = 0; c < 2; c++) begin
        st_r.ch[c].thresh_slope     <= btl_pkg::THRESH_SLOPE_RST;
        st_r.ch[c].act_thresh_slope <= btl_pkg::THRESH_SLOPE_RST;
        st_r.ch[c].knee             <= btl_pkg::KNEE_RST;
        st_r.ch[c].act_knee         <= btl_pkg::KNEE_RST;
        st_r.ch[c].clip             <= btl_pkg::CLIP_RST;
        st_r.ch[c].act_clip         <= btl_pkg::CLIP_RST;
        st_r.ch[c].gain             <= btl_pkg::GAIN_UNITY;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign reg_rdata = st_r.rdata;
  assign in_ready  = st_r.in_rdy;
  assign out_valid = st_r.out_vld;
  assign out_left  = st_r.buf_data[0][SAMPLE_W-1:0];
  assign out_right = st_r.buf_data[0][2*SAMPLE_W-1:SAMPLE_W];

endmodule

// ==== test/btl_limiter_checker.sv ====
// btl_limiter_checker: port-level assertions for the limiter block
// assumes it is bound onto btl_limiter, one clock domain, async low reset
`timescale 1ns/1ps
module btl_chk #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          supply_code,
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire logic [SAMPLE_W-1:0] in_left,
  input wire logic [SAMPLE_W-1:0] in_right,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic [SAMPLE_W-1:0] out_left,
  input wire logic [SAMPLE_W-1:0] out_right
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // two pushes in a row while the reader stalls
  sequence s_fill;
    in_valid && in_ready && !out_ready ##1 in_valid && in_ready && !out_ready;
  endsequence
  // knee write followed by a read of the same place
  sequence s_knee_wr;
    reg_wr && reg_addr == btl_pkg::LEFT_KNEE_OFF ##1 reg_addr == btl_pkg::LEFT_KNEE_OFF;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_fill_block: assert property (s_fill |=> !in_ready)
    else $error("buffer took a third pair");
  chk_knee_readback: assert property (s_knee_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("knee register read back wrong");
  chk_accept_valid: assert property (in_valid && in_ready |=> out_valid)
    else $error("accepted pair not presented");
  chk_out_hold: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_left) && $stable(out_right))
    else $error("output changed while stalled");
  chk_drain_ready: assert property (out_valid && out_ready && !in_valid |=> in_ready)
    else $error("no room after a pop");
  chk_empty_ready: assert property (!out_valid |-> in_ready)
    else $error("empty buffer refused input");
  chk_unmapped_zero: assert property ((reg_addr < 8'h0E || reg_addr > 8'h1A) &&
      $stable(reg_addr) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rsvd_zero: assert property (reg_addr == btl_pkg::LEFT_MODE_RATES_OFF &&
      $stable(reg_addr) |-> !reg_rdata[3])
    else $error("reserved bit reads one");
  chk_supply_read: assert property (reg_addr == btl_pkg::SUPPLY_OFF && $stable(reg_addr) |->
      reg_rdata == $past(supply_code, 3))
    else $error("supply reading not passed through");
endmodule
bind btl_limiter btl_chk #(.SAMPLE_W(SAMPLE_W)) i_chk (.clk(clk), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .supply_code(supply_code), .in_valid(in_valid), .in_ready(in_ready), .in_left(in_left),
  .in_right(in_right), .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
  .out_right(out_right));

// ==== test/btl_src_model.sv ====
// btl_src_model: upstream sample source feeding the limiter input stream
// assumes the caller starts each send just after a rising edge
`timescale 1ns/1ps
module btl_src_model #(
  parameter int SW = 24
) (
  input  wire logic clk,
  input  wire logic in_ready,
  output logic      in_valid,
  output logic [SW-1:0] in_left,
  output logic [SW-1:0] in_right
);
  initial begin
    in_valid = 1'b0;
    in_left = '0;
    in_right = '0;
  end
  // offer one pair, hold it until taken; hold keeps valid up for the next pair
  task automatic send(input logic [SW-1:0] l, r, input logic hold, output logic ok);
    int n;
    ok = 1'b0;
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    for (n = 0; n < 50 && !ok; n++) begin
      @(negedge clk);
      ok = (in_ready === 1'b1);
    end
    @(posedge clk);
    // released lines show the inverse of the last pair
    if (!hold) begin
      in_valid <= 1'b0;
      in_left <= ~l;
      in_right <= ~r;
    end
  endtask
endmodule

// ==== test/tb.sv ====
// tb: self-checking bench for the limiter block
// assumes the source model feeds the input stream and the bench drains the output
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset_n, reg_wr, in_valid, in_ready, out_valid, out_ready, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, supply_code;
  logic [23:0] in_left, in_right, out_left, out_right;
  int n_fail = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  btl_limiter #(.SAMPLE_W(24)) i_dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_code(supply_code), .in_valid(in_valid), .in_ready(in_ready), .in_left(in_left),
    .in_right(in_right), .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
    .out_right(out_right));
  btl_src_model #(.SW(24)) i_src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read with a mask on the bits that matter
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check({16'h0000, reg_rdata & m}, {16'h0000, e});
  endtask
  // one pair offered through the source model, a refusal ends the run
  task automatic sendc(input logic [23:0] l, r, input logic hold);
    i_src.send(l, r, hold, ok);
    if (!ok) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, ok, 1'b1);
      report_and_stop();
    end
  endtask
  // one pair through the block, output judged when it appears
  task automatic xfer(input logic [23:0] l, r, el, er);
    int n;
    @(posedge clk);
    out_ready <= 1'b1;
    i_src.send(l, r, 1'b0, ok);
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      if (out_valid === 1'b1) break;
    end
    if (!ok || n == 50) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, out_valid, 1'b1);
      report_and_stop();
    end
    check(out_left, el);
    check(out_right, er);
    @(posedge clk);
  endtask
  task automatic sup(input logic [7:0] v);
    supply_code <= v;
    repeat (4) @(posedge clk);
    xfer(24'h000000, 24'h000000, 24'h000000, 24'h000000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ra [8] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    logic [7:0] rv [8] = '{8'hA0, 8'h51, 8'h22, 8'hA8, 8'h51, 8'h22, 8'hFF, 8'hFF};
    for (int i = 0; i < 8; i++) rdc(ra[i], 8'hFF, rv[i]);
    wr(8'h10, 8'h80);
    rdc(8'h10, 8'hFF, 8'h80);
    wr(8'h0E, 8'hFF);
    rdc(8'h0E, 8'hFF, 8'hF7);
    wr(8'h0F, 8'hFF);
    rdc(8'h0F, 8'hFF, 8'hFB);
    wr(8'h30, 8'h55);
    rdc(8'h30, 8'hFF, 8'h00);
    wr(8'h0E, 8'hA0);
    wr(8'h0F, 8'h51);
    wr(8'h10, 8'h22);
    rdc(8'h1A, 8'hFF, 8'h80);
  endtask
  task automatic t_buf();
    @(posedge clk);
    out_ready <= 1'b0;
    sendc(24'h000111, 24'h000222, 1'b1);
    sendc(24'h000333, 24'h000444, 1'b0);
    @(negedge clk);
    check({23'h0, in_ready}, 24'h000000);
    @(posedge clk);
    out_ready <= 1'b1;
    @(negedge clk);
    check(out_left, 24'h000111);
    @(negedge clk);
    check(out_right, 24'h000444);
    @(negedge clk);
    check({23'h0, out_valid}, 24'h000000);
  endtask
  task automatic t_clip();
    wr(8'h14, 8'h10);
    sup(8'h80);
    xfer(24'h7FFFFF, 24'h000100, 24'h087FFF, 24'h000100);
    xfer(24'h800000, 24'h7FFFFF, 24'hF78001, 24'h7FFFFF);
    wr(8'h14, 8'hFF);
  endtask
  task automatic t_mute();
    wr(8'h0E, 8'hA2);
    sup(8'h10);
    xfer(24'h000100, 24'h000100, 24'h000000, 24'h000100);
    sup(8'h24);
    xfer(24'h000100, 24'h000100, 24'h000000, 24'h000100);
    sup(8'h80);
    xfer(24'h000100, 24'h000100, 24'h000100, 24'h000100);
  endtask
  task automatic t_modes();
    wr(8'h0E, 8'hA3);
    sup(8'h80);
    xfer(24'h7FFFFF, 24'h000000, 24'h7FFFFF, 24'h000000);
    wr(8'h0F, 8'h00);
    wr(8'h0E, 8'h01);
    xfer(24'h7FFFFF, 24'h000000, 24'h7FFFFF, 24'h000000);
    xfer(24'h7FFFFF, 24'h000000, 24'h0FFFFF, 24'h000000);
    xfer(24'h7FFFFF, 24'h000000, 24'h0FFFFF, 24'h000000);
    xfer(24'h000100, 24'h000000, 24'h000080, 24'h000000);
    xfer(24'h000100, 24'h000000, 24'h000081, 24'h000000);
    rdc(8'h19, 8'h88, 8'h08);
  endtask
  // tracking below the knee: 2:1 slope, then 4:1 slope with threshold code 1, low enough to hit the floor
  task automatic t_track();
    wr(8'h0F, 8'h51);
    wr(8'h0E, 8'h05);
    sup(8'h10);
    xfer(24'h7FFFFF, 24'h000000, 24'h26147A, 24'h000000);
    wr(8'h0F, 8'h0B);
    xfer(24'h000000, 24'h000000, 24'h000000, 24'h000000);
    xfer(24'h7FFFFF, 24'h000000, 24'h0FFFFF, 24'h000000);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    supply_code = 8'h80;
    out_ready = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_buf();
    t_clip();
    t_mute();
    t_modes();
    t_track();
    report_and_stop();
  end
endmodule
